// ===== verilog/dhc_map.svh
// register offsets, field positions, reset values and write masks of the debug hold block
`ifndef DHC_MAP_SVH
`define DHC_MAP_SVH
`define DHC_ADDR_W 12
`define DHC_OFF_ID 12'h000
`define DHC_OFF_CTL0 12'h004
`define DHC_OFF_CTL1 12'h008
`define DHC_CTL0_RESET 32'h0000_0000
`define DHC_CTL1_RESET 32'h0000_0000
// writable bits, everything else is reserved and reads zero
`define DHC_CTL0_MASK 32'h0809_9707
`define DHC_CTL1_MASK 32'h0007_0400
`define DHC_PSTRB_FULL 4'hF
// arbitrary identity value, names no real part
`define DHC_ID_VALUE 32'h5A5A_0001
// control register zero fields
`define DHC_B_SLEEP 0
`define DHC_B_DSLP 1
`define DHC_B_STBY 2
`define DHC_B_FWDG 8
`define DHC_B_WWDG 9
`define DHC_B_T0 10
`define DHC_B_T2 12
`define DHC_B_I2C0 15
`define DHC_B_I2C1 16
`define DHC_B_T5 19
`define DHC_B_T13 27
// control register one fields
`define DHC_B_RTC 10
`define DHC_B_T14 16
`define DHC_B_T15 17
`define DHC_B_T16 18
`endif

// ===== verilog/dhc_pkg.sv
// types shared by the debug hold block
package dhc_pkg;
   // power mode reported by the power controller
   typedef enum logic [1:0] {
      DHC_PM_RUN = 2'b00,
      DHC_PM_SLEEP = 2'b01,
      DHC_PM_DSLP = 2'b10,
      DHC_PM_STBY = 2'b11
   } dhc_pwr_mode_t;
   // bus slave state
   typedef enum logic {
      DHC_APB_IDLE = 1'b0,
      DHC_APB_ACK = 1'b1
   } dhc_apb_st_t;
   // freeze requests towards the held peripherals
   typedef struct packed {
      logic timer_zero_freeze;
      logic timer_two_freeze;
      logic timer_five_freeze;
      logic timer_thirteen_freeze;
      logic timer_fourteen_freeze;
      logic timer_fifteen_freeze;
      logic timer_sixteen_freeze;
      logic i2c_unit_zero_timeout_freeze;
      logic i2c_unit_one_timeout_freeze;
      logic rtc_freeze;
      logic window_watchdog_freeze;
      logic free_watchdog_freeze;
   } dhc_freeze_t;
   // clock steering towards the clock unit
   typedef struct packed {
      logic ahb_clock_keep;
      logic sys_clock_from_irc8;
   } dhc_clk_ctl_t;
   // one pin seen as two signals
   typedef struct packed {
      logic o;
      logic oe;
   } dhc_pin_drv_t;
endpackage

// ===== verilog/dhc_swd_pin_mux.sv
// serial wire debug pin owner: debug port or general purpose io
`timescale 1ns/1ps
module dhc_swd_pin_mux (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic swd_enable,
   input wire logic pin_swclk_in,
   input wire logic pin_swdio_in,
   input wire dhc_pkg::dhc_pin_drv_t dp_swdio_drv,
   input wire dhc_pkg::dhc_pin_drv_t gpio_swclk_drv,
   input wire dhc_pkg::dhc_pin_drv_t gpio_swdio_drv,
   output dhc_pkg::dhc_pin_drv_t pin_swclk_drv,
   output dhc_pkg::dhc_pin_drv_t pin_swdio_drv,
   output logic dp_swclk,
   output logic dp_swdio_in,
   output logic gpio_swclk_in,
   output logic gpio_swdio_in
);
   dhc_pkg::dhc_pin_drv_t clk_drv_d, clk_drv_q, dio_drv_d, dio_drv_q;
   logic dp_clk_d, dp_clk_q, dp_dio_d, dp_dio_q, g_clk_d, g_clk_q, g_dio_d, g_dio_q;

   // swclk is only ever an input for the debug port: the tool drives it
   always_comb begin
      clk_drv_d = gpio_swclk_drv;
      dio_drv_d = gpio_swdio_drv;
      dp_clk_d = 1'b0;
      dp_dio_d = 1'b0;
      g_clk_d = pin_swclk_in;
      g_dio_d = pin_swdio_in;
      if (swd_enable) begin
         clk_drv_d = '0;
         dio_drv_d = dp_swdio_drv;
         dp_clk_d = pin_swclk_in;
         dp_dio_d = pin_swdio_in;
         g_clk_d = 1'b0;
         g_dio_d = 1'b0;
      end
   end

   // released pins belong wholly to gpio, the debug port sees idle zeros
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         clk_drv_q <= '0;
         dio_drv_q <= '0;
         dp_clk_q <= 1'b0;
         dp_dio_q <= 1'b0;
         g_clk_q <= 1'b0;
         g_dio_q <= 1'b0;
      end else begin
         clk_drv_q <= clk_drv_d;
         dio_drv_q <= dio_drv_d;
         dp_clk_q <= dp_clk_d;
         dp_dio_q <= dp_dio_d;
         g_clk_q <= g_clk_d;
         g_dio_q <= g_dio_d;
      end
   end

   assign pin_swclk_drv = clk_drv_q;
   assign pin_swdio_drv = dio_drv_q;
   assign dp_swclk = dp_clk_q;
   assign dp_swdio_in = dp_dio_q;
   assign gpio_swclk_in = g_clk_q;
   assign gpio_swdio_in = g_dio_q;

   // rstn in the antecedent: an attempt on the release edge would see reset values
   property p_release;
      @(posedge clk_sys) disable iff (!rstn)
      rstn && !swd_enable |=> pin_swdio_drv == $past(gpio_swdio_drv) && !dp_swclk;
   endproperty
   a_release: assert property (p_release) else $error("released pin not given to gpio");
   property p_swd_own;
      @(posedge clk_sys) disable iff (!rstn)
      rstn && swd_enable |=> pin_swdio_drv == $past(dp_swdio_drv) && !pin_swclk_drv.oe;
   endproperty
   a_swd_own: assert property (p_swd_own) else $error("debug port does not own pins");
endmodule // dhc_swd_pin_mux

// ===== verilog/dhc_debug_hold.sv
// debug hold control: apb registers, low power clock keep and peripheral freeze
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "dhc_map.svh"
module dhc_debug_hold #(
   // arbitrary identity value
   parameter logic [31:0] PART_ID = `DHC_ID_VALUE
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic core_halted,
   input wire dhc_pkg::dhc_pwr_mode_t pwr_mode,
   output dhc_pkg::dhc_freeze_t freeze,
   output dhc_pkg::dhc_clk_ctl_t clk_ctl,
   output logic system_reset_req,
   input wire logic swd_enable,
   input wire logic pin_swclk_in,
   input wire logic pin_swdio_in,
   output dhc_pkg::dhc_pin_drv_t pin_swclk_drv,
   output dhc_pkg::dhc_pin_drv_t pin_swdio_drv,
   input wire dhc_pkg::dhc_pin_drv_t dp_swdio_drv,
   output logic dp_swclk,
   output logic dp_swdio_in,
   input wire dhc_pkg::dhc_pin_drv_t gpio_swclk_drv,
   input wire dhc_pkg::dhc_pin_drv_t gpio_swdio_drv,
   output logic gpio_swclk_in,
   output logic gpio_swdio_in
);
   dhc_pkg::dhc_apb_st_t st_d, st_q;
   logic ready_d, ready_q, err_d, err_q;
   logic [31:0] rdata_d, rdata_q, ctl0_d, ctl0_q, ctl1_d, ctl1_q;
   logic hit_id, hit_ctl0, hit_ctl1, mapped;
   dhc_pkg::dhc_pwr_mode_t pm_q;
   dhc_pkg::dhc_freeze_t frz_d, frz_q;
   dhc_pkg::dhc_clk_ctl_t clk_d, clk_q;
   logic rst_req_d, rst_req_q;

   ////////////////////////////////////////////////////////////////////////////
   // register bus

   // address decode on full byte address, so misaligned offsets are unmapped
   assign hit_id = (paddr == `DHC_OFF_ID);
   assign hit_ctl0 = (paddr == `DHC_OFF_CTL0);
   assign hit_ctl1 = (paddr == `DHC_OFF_CTL1);
   assign mapped = hit_id | hit_ctl0 | hit_ctl1;

   // one wait state: ready is raised from a flop, the write lands on the ready edge
   always_comb begin
      st_d = st_q;
      ready_d = 1'b0;
      err_d = 1'b0;
      rdata_d = 32'h0000_0000;
      ctl0_d = ctl0_q;
      ctl1_d = ctl1_q;
      case (st_q)
         dhc_pkg::DHC_APB_IDLE: begin
            if (psel && penable) begin
               st_d = dhc_pkg::DHC_APB_ACK;
               ready_d = 1'b1;
               // partial writes are refused: the hold bits are word registers
               err_d = !mapped || (pwrite && pstrb != `DHC_PSTRB_FULL);
               if (!pwrite) begin
                  if (hit_id) begin
                     rdata_d = PART_ID;
                  end else if (hit_ctl0) begin
                     rdata_d = ctl0_q;
                  end else if (hit_ctl1) begin
                     rdata_d = ctl1_q;
                  end
               end
            end
         end
         dhc_pkg::DHC_APB_ACK: begin
            st_d = dhc_pkg::DHC_APB_IDLE;
            rdata_d = rdata_q;
            err_d = err_q;
            // an identification write falls through with no effect
            if (psel && penable && pwrite && !err_q) begin
               if (hit_ctl0) begin
                  ctl0_d = pwdata & `DHC_CTL0_MASK;
               end
               if (hit_ctl1) begin
                  ctl1_d = pwdata & `DHC_CTL1_MASK;
               end
            end
         end
         default: begin
            st_d = dhc_pkg::DHC_APB_IDLE;
         end
      endcase
   end

   // rstn is the power reset, no other reset reaches the hold bits
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         st_q <= dhc_pkg::DHC_APB_IDLE;
         ready_q <= 1'b0;
         err_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         ctl0_q <= `DHC_CTL0_RESET;
         ctl1_q <= `DHC_CTL1_RESET;
      end else begin
         st_q <= st_d;
         ready_q <= ready_d;
         err_q <= err_d;
         rdata_q <= rdata_d;
         ctl0_q <= ctl0_d;
         ctl1_q <= ctl1_d;
      end
   end

   assign pready = ready_q;
   assign pslverr = err_q;
   assign prdata = rdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // low power clock keep

   // the clock unit follows clk_ctl; a cleared bit leaves normal gating alone
   always_comb begin
      clk_d = '0;
      case (pwr_mode)
         dhc_pkg::DHC_PM_SLEEP: begin
            clk_d.ahb_clock_keep = ctl0_q[`DHC_B_SLEEP];
         end
         dhc_pkg::DHC_PM_DSLP: begin
            clk_d.ahb_clock_keep = ctl0_q[`DHC_B_DSLP];
            clk_d.sys_clock_from_irc8 = ctl0_q[`DHC_B_DSLP];
         end
         dhc_pkg::DHC_PM_STBY: begin
            clk_d.ahb_clock_keep = ctl0_q[`DHC_B_STBY];
            clk_d.sys_clock_from_irc8 = ctl0_q[`DHC_B_STBY];
         end
         default: begin
            clk_d = '0;
         end
      endcase
      // standby held by the debugger keeps state that a real wakeup would lose
      rst_req_d = (pm_q == dhc_pkg::DHC_PM_STBY) && (pwr_mode != dhc_pkg::DHC_PM_STBY)
         && ctl0_q[`DHC_B_STBY];
   end

   ////////////////////////////////////////////////////////////////////////////
   // peripheral freeze

   // each freeze is the hold bit gated by the halt, released with the halt
   always_comb begin
      frz_d = '0;
      frz_d.timer_zero_freeze = ctl0_q[`DHC_B_T0];
      frz_d.timer_two_freeze = ctl0_q[`DHC_B_T2];
      frz_d.timer_five_freeze = ctl0_q[`DHC_B_T5];
      frz_d.timer_thirteen_freeze = ctl0_q[`DHC_B_T13];
      frz_d.timer_fourteen_freeze = ctl1_q[`DHC_B_T14];
      frz_d.timer_fifteen_freeze = ctl1_q[`DHC_B_T15];
      frz_d.timer_sixteen_freeze = ctl1_q[`DHC_B_T16];
      frz_d.i2c_unit_zero_timeout_freeze = ctl0_q[`DHC_B_I2C0];
      frz_d.i2c_unit_one_timeout_freeze = ctl0_q[`DHC_B_I2C1];
      frz_d.rtc_freeze = ctl1_q[`DHC_B_RTC];
      frz_d.window_watchdog_freeze = ctl0_q[`DHC_B_WWDG];
      frz_d.free_watchdog_freeze = ctl0_q[`DHC_B_FWDG];
      if (!core_halted) begin
         frz_d = '0;
      end
   end

   // one cycle of latency: the peripherals see a registered, glitch free freeze
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         pm_q <= dhc_pkg::DHC_PM_RUN;
         clk_q <= '0;
         rst_req_q <= 1'b0;
         frz_q <= '0;
      end else begin
         pm_q <= pwr_mode;
         clk_q <= clk_d;
         rst_req_q <= rst_req_d;
         frz_q <= frz_d;
      end
   end

   assign clk_ctl = clk_q;
   assign system_reset_req = rst_req_q;
   assign freeze = frz_q;

   ////////////////////////////////////////////////////////////////////////////
   // debug pins

   dhc_swd_pin_mux u_pins (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .swd_enable(swd_enable),
      .pin_swclk_in(pin_swclk_in),
      .pin_swdio_in(pin_swdio_in),
      .dp_swdio_drv(dp_swdio_drv),
      .gpio_swclk_drv(gpio_swclk_drv),
      .gpio_swdio_drv(gpio_swdio_drv),
      .pin_swclk_drv(pin_swclk_drv),
      .pin_swdio_drv(pin_swdio_drv),
      .dp_swclk(dp_swclk),
      .dp_swdio_in(dp_swdio_in),
      .gpio_swclk_in(gpio_swclk_in),
      .gpio_swdio_in(gpio_swdio_in)
   );

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);

   property p_stby_clk;
      pwr_mode == dhc_pkg::DHC_PM_STBY && ctl0_q[2] |=> clk_ctl == 2'b11;
   endproperty
   a_stby_clk: assert property (p_stby_clk) else $error("standby clocks not kept");
   property p_stby_rst;
      pwr_mode == dhc_pkg::DHC_PM_STBY ##1 pwr_mode != dhc_pkg::DHC_PM_STBY && ctl0_q[2]
         |=> system_reset_req ##1 !system_reset_req;
   endproperty
   a_stby_rst: assert property (p_stby_rst) else $error("no reset on standby exit");
   property p_dslp_clk;
      pwr_mode == dhc_pkg::DHC_PM_DSLP |=> clk_ctl == {2{$past(ctl0_q[1])}};
   endproperty
   a_dslp_clk: assert property (p_dslp_clk) else $error("deep-sleep clock steering wrong");
   property p_sleep_clk;
      pwr_mode == dhc_pkg::DHC_PM_SLEEP |=> clk_ctl == {$past(ctl0_q[0]), 1'b0};
   endproperty
   a_sleep_clk: assert property (p_sleep_clk) else $error("sleep ahb clock wrong");
   property p_run_free;
      !core_halted |=> freeze == '0;
   endproperty
   a_run_free: assert property (p_run_free) else $error("freeze without halt");
   property p_timers;
      core_halted |=> freeze.timer_thirteen_freeze == $past(ctl0_q[27])
         && freeze.timer_five_freeze == $past(ctl0_q[19])
         && freeze.timer_two_freeze == $past(ctl0_q[12])
         && freeze.timer_zero_freeze == $past(ctl0_q[10]);
   endproperty
   a_timers: assert property (p_timers) else $error("timer freeze mismatch");
   property p_periph;
      core_halted |=> freeze.i2c_unit_one_timeout_freeze == $past(ctl0_q[16])
         && freeze.i2c_unit_zero_timeout_freeze == $past(ctl0_q[15])
         && freeze.window_watchdog_freeze == $past(ctl0_q[9])
         && freeze.free_watchdog_freeze == $past(ctl0_q[8]);
   endproperty
   a_periph: assert property (p_periph) else $error("i2c or watchdog freeze mismatch");
   property p_ctl1;
      core_halted |=> freeze.rtc_freeze == $past(ctl1_q[10])
         && freeze.timer_sixteen_freeze == $past(ctl1_q[18])
         && freeze.timer_fifteen_freeze == $past(ctl1_q[17])
         && freeze.timer_fourteen_freeze == $past(ctl1_q[16]);
   endproperty
   a_ctl1: assert property (p_ctl1) else $error("control one freeze mismatch");
   property p_id_read;
      psel && penable && pready && !pwrite && paddr == 12'h000 |-> prdata == PART_ID;
   endproperty
   a_id_read: assert property (p_id_read) else $error("identification value wrong");
   property p_power_reset;
      @(posedge clk_sys) disable iff (1'b0) !rstn |=> ctl0_q == 32'h0000_0000;
   endproperty
   a_power_reset: assert property (p_power_reset) else $error("control zero not cleared");
   property p_sw_only;
      !(psel && penable && pready && pwrite) |=> $stable(ctl0_q) && $stable(ctl1_q);
   endproperty
   a_sw_only: assert property (p_sw_only) else $error("hold bit changed without write");
   property p_ctl0_wr;
      psel && penable && pready && pwrite && paddr == 12'h004 && pstrb == 4'hF
         |=> ctl0_q == ($past(pwdata) & 32'h0809_9707);
   endproperty
   a_ctl0_wr: assert property (p_ctl0_wr) else $error("control zero write lost");
   property p_ready;
      psel && penable && !pready |=> pready ##1 !pready;
   endproperty
   a_ready: assert property (p_ready) else $error("ready not one cycle after access");
   c_stby_exit: cover property (system_reset_req);
   c_freeze_held: cover property (core_halted ##1 freeze != '0);
   c_sleep_keep: cover property (clk_ctl.ahb_clock_keep && !clk_ctl.sys_clock_from_irc8);
   c_err: cover property (pready && pslverr);
endmodule // dhc_debug_hold

// ===== bench/dhc_probe_model.sv
// behavioural debug probe: drives the serial clock and shifts one byte out on the data line
`timescale 1ns/1ps
module dhc_probe_model (
   input wire logic clk_sys,
   input wire logic go,
   input wire logic [7:0] tx_byte,
   output logic swclk,
   output logic swdio_o,
   output logic swdio_oe,
   output logic busy
);
   logic [6:0] step_q = 7'h00;
   logic [7:0] shift_q = 8'h00;
   // idle probe: clock low, data line released
   logic clk_q = 1'b0;
   logic dio_q = 1'b0;
   logic oe_q = 1'b0;
   logic busy_q = 1'b0;

   // eight system cycles per bit, msb first, data changes only while the clock is low
   // the clock stands still between frames, the line then falls back to its pull-up
   always @(posedge clk_sys) begin
      if (!busy_q && go) begin
         busy_q <= 1'b1;
         step_q <= 7'h00;
         shift_q <= tx_byte;
      end else if (busy_q && step_q == 7'h40) begin
         busy_q <= 1'b0;
         clk_q <= 1'b0;
         oe_q <= 1'b0;
      end else if (busy_q) begin
         step_q <= step_q + 7'h01;
         clk_q <= step_q[2];
         oe_q <= 1'b1;
         if (step_q[2:0] == 3'h0) begin
            dio_q <= shift_q[7];
            shift_q <= {shift_q[6:0], 1'b0};
         end
      end
   end

   assign swclk = clk_q;
   assign swdio_o = dio_q;
   assign swdio_oe = oe_q;
   assign busy = busy_q;
endmodule // dhc_probe_model

// ===== bench/debug_hold_control_bench.sv
// self-checking bench for the debug hold block with a probe on the debug pins
`timescale 1ns/1ps
module debug_hold_control_bench;
   // arbitrary identity value, names no real part
   localparam logic [31:0] BENCH_ID = 32'h1234_ABCD;
   localparam logic [4:0] FZ_BIT [12] = '{5'h0A, 5'h0C, 5'h13, 5'h1B, 5'h10, 5'h11,
                                          5'h12, 5'h0F, 5'h10, 5'h0A, 5'h09, 5'h08};
   localparam logic FZ_SEL [12] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1,
                                    1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
   localparam logic [2:0] PT_BITS [7] = '{3'h1, 3'h2, 3'h4, 3'h6, 3'h1, 3'h3, 3'h7};
   localparam logic [1:0] PT_MODE [7] = '{2'h1, 2'h2, 2'h3, 2'h1, 2'h2, 2'h3, 2'h0};
   localparam logic [1:0] PT_CLK [7] = '{2'h2, 2'h3, 2'h3, 2'h0, 2'h0, 2'h0, 2'h0};
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hF;
   logic pready;
   logic [31:0] prdata;
   logic pslverr;
   logic core_halted = 1'b0;
   dhc_pkg::dhc_pwr_mode_t pwr_mode = dhc_pkg::DHC_PM_RUN;
   dhc_pkg::dhc_freeze_t freeze;
   dhc_pkg::dhc_clk_ctl_t clk_ctl;
   logic system_reset_req;
   logic swd_enable = 1'b1;
   wire logic pin_swclk_in;
   wire logic pin_swdio_in;
   dhc_pkg::dhc_pin_drv_t pin_swclk_drv;
   dhc_pkg::dhc_pin_drv_t pin_swdio_drv;
   dhc_pkg::dhc_pin_drv_t dp_swdio_drv = 2'h0;
   dhc_pkg::dhc_pin_drv_t gpio_swclk_drv = 2'h0;
   dhc_pkg::dhc_pin_drv_t gpio_swdio_drv = 2'h0;
   logic dp_swclk;
   logic dp_swdio_in;
   logic gpio_swclk_in;
   logic gpio_swdio_in;
   logic go = 1'b0;
   logic probe_clk;
   logic probe_o;
   logic probe_oe;
   logic probe_busy;
   logic [7:0] cap = 8'h00;
   logic dp_clk_prev = 1'b0;
   int n_errors = 0;
   int n_compared = 0;
   int cyc = 0;

   always #2 clk_sys = ~clk_sys;

   // pin levels: data line has a pull-up, so a released line reads high
   assign pin_swdio_in = probe_oe ? probe_o : (pin_swdio_drv.oe ? pin_swdio_drv.o : 1'b1);
   assign pin_swclk_in = pin_swclk_drv.oe ? pin_swclk_drv.o : probe_clk;

   dhc_debug_hold #(.PART_ID(BENCH_ID)) uut (
      .clk_sys(clk_sys), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .core_halted(core_halted), .pwr_mode(pwr_mode), .freeze(freeze),
      .clk_ctl(clk_ctl), .system_reset_req(system_reset_req), .swd_enable(swd_enable),
      .pin_swclk_in(pin_swclk_in), .pin_swdio_in(pin_swdio_in),
      .pin_swclk_drv(pin_swclk_drv), .pin_swdio_drv(pin_swdio_drv),
      .dp_swdio_drv(dp_swdio_drv), .dp_swclk(dp_swclk), .dp_swdio_in(dp_swdio_in),
      .gpio_swclk_drv(gpio_swclk_drv), .gpio_swdio_drv(gpio_swdio_drv),
      .gpio_swclk_in(gpio_swclk_in), .gpio_swdio_in(gpio_swdio_in));

   dhc_probe_model probe (
      .clk_sys(clk_sys), .go(go), .tx_byte(8'hA5), .swclk(probe_clk), .swdio_o(probe_o),
      .swdio_oe(probe_oe), .busy(probe_busy));

   // shift in the data line at each rising debug clock that reaches the debug port
   always @(posedge clk_sys) begin
      if (dp_swclk === 1'b1 && dp_clk_prev === 1'b0) cap <= {cap[6:0], dp_swdio_in};
      dp_clk_prev <= dp_swclk;
   end

   // cycle ceiling, far above the few hundred cycles the run needs
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         n_errors++;
         end_of_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("compared %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
         input logic [3:0] s, output logic [31:0] rd, output logic err);
      @(posedge clk_sys);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk_sys);
      penable <= 1'b1;
      // no wait count assumed here: only the bench ceiling ends a hung access
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e_err);
      logic [31:0] rd;
      logic err;
      apb(a, 1'b1, d, 4'hF, rd, err);
      check({31'h0, err}, {31'h0, e_err});
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic e_err);
      logic [31:0] rd;
      logic err;
      apb(a, 1'b0, 32'h0, 4'hF, rd, err);
      check(rd, e);
      check({31'h0, err}, {31'h0, e_err});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // reset values, decode, full write of the writable bits, read-only identity, refused writes
   task automatic t_regs();
      logic [31:0] rd;
      logic err;
      rd_chk(12'h000, BENCH_ID, 1'b0);
      rd_chk(12'h004, 32'h0, 1'b0);
      rd_chk(12'h008, 32'h0, 1'b0);
      rd_chk(12'h00C, 32'h0, 1'b1);
      wr(12'h004, 32'h0809_9707, 1'b0);
      rd_chk(12'h004, 32'h0809_9707, 1'b0);
      wr(12'h008, 32'h0007_0400, 1'b0);
      rd_chk(12'h008, 32'h0007_0400, 1'b0);
      wr(12'h000, 32'hFFFF_FFFF, 1'b0);
      rd_chk(12'h000, BENCH_ID, 1'b0);
      apb(12'h004, 1'b1, 32'h0, 4'h3, rd, err);
      check({31'h0, err}, 32'h1);
      rd_chk(12'h004, 32'h0809_9707, 1'b0);
      wr(12'h010, 32'h1, 1'b1);
      $display("test registers done");
   endtask

   // each hold bit alone: no freeze while running, only its own freeze while halted
   task automatic t_freeze();
      logic [31:0] v;
      for (int i = 0; i < 12; i++) begin
         v = 32'h1 << FZ_BIT[i];
         wr(12'h004, FZ_SEL[i] ? 32'h0 : v, 1'b0);
         wr(12'h008, FZ_SEL[i] ? v : 32'h0, 1'b0);
         @(posedge clk_sys);
         core_halted <= 1'b1;
         @(posedge clk_sys);
         #1;
         check({20'h0, freeze}, {20'h0, 12'h800 >> i});
         @(posedge clk_sys);
         core_halted <= 1'b0;
         @(posedge clk_sys);
         #1;
         check({20'h0, freeze}, 32'h0);
      end
      $display("test freeze done");
   endtask

   // clock keep per mode and bit, reset request only on leaving standby with its bit
   task automatic t_power();
      for (int i = 0; i < 7; i++) begin
         wr(12'h004, {29'h0, PT_BITS[i]}, 1'b0);
         @(posedge clk_sys);
         pwr_mode <= dhc_pkg::dhc_pwr_mode_t'(PT_MODE[i]);
         @(posedge clk_sys);
         #1;
         check({30'h0, clk_ctl}, {30'h0, PT_CLK[i]});
         @(posedge clk_sys);
         pwr_mode <= dhc_pkg::DHC_PM_RUN;
         @(posedge clk_sys);
         #1;
         check({31'h0, system_reset_req}, {31'h0, PT_MODE[i] == 2'h3 && PT_BITS[i][2]});
         @(posedge clk_sys);
         #1;
         check({31'h0, system_reset_req}, 32'h0);
      end
      rd_chk(12'h004, 32'h7, 1'b0);
      $display("test power done");
   endtask

   // probe frame through the debug port, then the pins handed to gpio
   task automatic t_pins();
      int n;
      logic [31:0] v;
      n = 0;
      @(posedge clk_sys);
      go <= 1'b1;
      @(posedge clk_sys);
      go <= 1'b0;
      #1;
      while (probe_busy === 1'b1 && n < 200) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      @(posedge clk_sys);
      #1;
      check({24'h0, cap}, 32'hA5);
      @(posedge clk_sys);
      dp_swdio_drv <= 2'h1;
      repeat (3) @(posedge clk_sys);
      #1;
      v = {26'h0, pin_swclk_drv.oe, pin_swdio_drv, dp_swdio_in, gpio_swclk_in, gpio_swdio_in};
      check(v, 32'h08);
      @(posedge clk_sys);
      swd_enable <= 1'b0;
      gpio_swclk_drv <= 2'h3;
      gpio_swdio_drv <= 2'h3;
      repeat (3) @(posedge clk_sys);
      #1;
      v = {24'h0, pin_swclk_drv, pin_swdio_drv, dp_swclk, dp_swdio_in, gpio_swclk_in,
           gpio_swdio_in};
      check(v, 32'hF3);
      $display("test pins done");
   endtask

   // a power reset in mid-run clears both control words
   task automatic t_power_reset();
      wr(12'h004, 32'h0809_9707, 1'b0);
      @(posedge clk_sys);
      rstn <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rstn <= 1'b1;
      rd_chk(12'h004, 32'h0, 1'b0);
      rd_chk(12'h008, 32'h0, 1'b0);
      $display("test power reset done");
   endtask

   // main sequence
   initial begin
      repeat (20) @(posedge clk_sys);
      rstn <= 1'b1;
      t_regs();
      t_freeze();
      t_power();
      t_pins();
      t_power_reset();
      end_of_test();
   end
endmodule // debug_hold_control_bench
